// *** bench/csx_core_checker.sv ***
// Port-level assertions for csx_core.
// Assumes software writes the operand and the command word with all strobes set.
`timescale 1ns/1ns
module csx_core_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] fetchAddr,
  input wire logic        fetchHalf,
  input wire logic        compactState
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] operand_q;
  // Only same-edge address and data capture is tracked; split captures go unchecked
  wire wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire cmdWr  = wrBoth && s_axi_awaddr == csx_pkg::OffCmd;
  wire opWr   = wrBoth && s_axi_awaddr == csx_pkg::OffOperand && s_axi_wstrb == 4'hF;
  wire rdAcc  = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk) begin
    if (opWr) operand_q <= s_axi_wdata;
  end
  sequence s_cmd(logic [3:0] c);
    cmdWr && s_axi_wdata[3:0] == c;
  endsequence
  sequence s_sel;
    cmdWr && (s_axi_wdata[3:0] == 4'h2 || s_axi_wdata[3:0] == 4'h3 || s_axi_wdata[3:0] == 4'h4);
  endsequence
  property p_step_full;
    logic [31:0] pc;
    (s_cmd(4'h1) ##0 (!compactState, pc = fetchAddr)) |-> ##[1:4] fetchAddr == pc + 32'h4;
  endproperty
  a_step_full: assert property (p_step_full) else $error("full step not plus four");
  property p_step_cmp;
    logic [31:0] pc;
    (s_cmd(4'h1) ##0 (compactState, pc = fetchAddr)) |-> ##[1:4] fetchAddr == pc + 32'h2;
  endproperty
  a_step_cmp: assert property (p_step_cmp) else $error("compact step not plus two");
  property p_branch_sel;
    s_sel |-> ##[1:4] (compactState == operand_q[0] && fetchAddr == (operand_q & 32'hFFFF_FFFE));
  endproperty
  a_branch_sel: assert property (p_branch_sel) else $error("branch state select wrong");
  property p_exc_full;
    (cmdWr && s_axi_wdata[3:0] >= 4'h6 && s_axi_wdata[3:0] <= 4'hB) |-> ##[1:4] !compactState;
  endproperty
  a_exc_full: assert property (p_exc_full) else $error("exception kept compact state");
  property p_pc_read;
    rdAcc && s_axi_araddr == csx_pkg::OffPc && compactState
      |=> s_axi_rdata == (($past(fetchAddr) & 32'hFFFF_FFFE) + 32'h4);
  endproperty
  a_pc_read: assert property (p_pc_read) else $error("compact pc read wrong");
  property p_flag_pos;
    rdAcc && s_axi_araddr == csx_pkg::OffStatus |=> s_axi_rdata[5] == $past(compactState);
  endproperty
  a_flag_pos: assert property (p_flag_pos) else $error("status bit 5 not state");
  property p_saved_hidden;
    rdAcc && s_axi_araddr == csx_pkg::OffSaved && compactState |=> s_axi_rdata == 32'h0;
  endproperty
  a_saved_hidden: assert property (p_saved_hidden) else $error("saved word seen");
  property p_half_fetch;
    fetchHalf == compactState;
  endproperty
  a_half_fetch: assert property (p_half_fetch) else $error("fetch width wrong");
endmodule

bind csx_core csx_core_checker u_chk (
  .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .fetchAddr(fetchAddr), .fetchHalf(fetchHalf), .compactState(compactState));

// *** bench/csx_core_tb.sv ***
// Self-checking bench for csx_core over its register bus.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ns
module csx_core_tb;
  logic        clk, rst, awValid, wValid, arValid, bReady, rReady;
  logic [7:0]  awAddr, arAddr;
  logic [3:0]  wStrb;
  logic [31:0] wData, rData, fetchAddr, v;
  logic [1:0]  bResp, rResp, r;
  logic        awReady, wReady, bValid, arReady, rValid, fetchHalf, compactState;
  int          failures, num_checks;
  int          cycles = 0;

  csx_core dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .fetchAddr(fetchAddr), .fetchHalf(fetchHalf), .compactState(compactState));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole run needs a few hundred cycles; generous margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awOk, wOk;
    awOk = 1'b0;
    wOk = 1'b0;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (!(awOk && wOk)) begin
      @(posedge clk);
      awOk = awOk || awReady;
      wOk = wOk || wReady;
      awValid <= !awOk;
      wValid <= !wOk;
    end
    do @(posedge clk); while (!bValid);
    r = bResp;
  endtask

  task automatic rd(input logic [7:0] a);
    arAddr <= a;
    arValid <= 1'b1;
    do @(posedge clk); while (!arReady);
    arValid <= 1'b0;
    do @(posedge clk); while (!rValid);
    v = rData;
    r = rResp;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string w);
    rd(a);
    chk(v, e, w);
  endtask

  // Polls busy so no command is dropped by the design
  task automatic cmd(input logic [3:0] c);
    int n;
    n = 0;
    wr(csx_pkg::OffCmd, {28'h0, c});
    do begin
      rd(csx_pkg::OffCtrl);
      n++;
    end while (v[1] !== 1'b0 && n < 20);
  endtask

  task automatic t_reset();
    chk(32'(compactState), 32'h0, "reset state");
    chk_rd(csx_pkg::OffStatus, csx_pkg::ResetStatus, "reset status");
    cmd(4'h1);
    chk(fetchAddr, csx_pkg::ResetPc + 32'h4, "full step");
    chk(32'(fetchHalf), 32'h0, "full fetch");
    $display("Test reset and full step done");
  endtask

  task automatic t_enter();
    logic [31:0] t;
    for (int i = 0; i < 3; i++) begin
      t = 32'h100 * (i + 1);
      wr(csx_pkg::OffOperand, t | 32'h1);
      cmd(4'h2 + 4'(i));
      chk(32'(compactState), 32'h1, "enter state");
      chk(fetchAddr, t, "enter target");
      wr(csx_pkg::OffOperand, 32'h0000_0800);
      cmd(4'h2 + 4'(i));
      chk(32'(compactState), 32'h0, "leave state");
    end
    $display("Test state select done");
  endtask

  task automatic t_compact();
    wr(csx_pkg::OffOperand, 32'h0000_0101);
    cmd(4'h2);
    cmd(4'h1);
    chk(fetchAddr, 32'h0000_0102, "compact step");
    chk(32'(fetchHalf), 32'h1, "half fetch");
    chk_rd(csx_pkg::OffPc, 32'h0000_0106, "pc read");
    rd(csx_pkg::OffStatus);
    chk(32'(v[5]), 32'h1, "status flag");
    chk_rd(csx_pkg::OffSaved, 32'h0, "saved hidden");
    wr(csx_pkg::OffOperand, 32'h0000_0203);
    cmd(4'hC);
    chk(fetchAddr, 32'h0000_0202, "pc write");
    wr(csx_pkg::OffReg0, 32'h1234_5677);
    chk_rd(csx_pkg::OffReg0, 32'h1234_5677, "low reg");
    rd(8'h40);
    chk(32'(r), 32'(csx_pkg::RespSlvErr), "unmapped");
    $display("Test compact state done");
  endtask

  task automatic t_exc();
    logic [31:0] vec [6];
    logic [31:0] off [6];
    vec = '{csx_pkg::VecUnd, csx_pkg::VecSwi, csx_pkg::VecPabt,
            csx_pkg::VecDabt, csx_pkg::VecIrq, csx_pkg::VecFiq};
    off = '{csx_pkg::LinkUndSwi, csx_pkg::LinkUndSwi, csx_pkg::LinkPabt,
            csx_pkg::LinkDabt, csx_pkg::LinkIrq, csx_pkg::LinkIrq};
    for (int i = 0; i < 6; i++) begin
      wr(csx_pkg::OffOperand, 32'h0000_0301);
      cmd(4'h2);
      cmd(4'h6 + 4'(i));
      chk(32'(compactState), 32'h0, "exc state");
      chk(fetchAddr, vec[i], "exc vector");
      chk_rd(csx_pkg::OffLink, 32'h300 + off[i], "link");
      rd(csx_pkg::OffSaved);
      chk(32'(v[5]), 32'h1, "saved flag");
      // Secondary returns: retry undefined, skip data-aborted instruction
      if (i == 0 || i == 3) begin
        wr(csx_pkg::OffOperand, 32'h300 + off[i] - (i == 0 ? 32'h2 : 32'h6));
        cmd(4'h5);
        chk(fetchAddr, (i == 0 ? 32'h300 : 32'h302), "handler return");
        chk(32'(compactState), 32'h1, "return state");
      end
    end
    $display("Test exceptions done");
  endtask

  task automatic t_restore();
    wr(csx_pkg::OffSaved, 32'h0000_00F3);
    wr(csx_pkg::OffOperand, 32'h0000_0501);
    cmd(4'h5);
    chk(32'(compactState), 32'h1, "restore set");
    chk(fetchAddr, 32'h0000_0500, "restore pc");
    wr(csx_pkg::OffOperand, 32'h0000_0600);
    cmd(4'h2);
    wr(csx_pkg::OffSaved, 32'h0000_00D3);
    cmd(4'h5);
    chk(32'(compactState), 32'h0, "restore clear");
    // Status write that leaves the state flag as it stands
    wr(csx_pkg::OffStatus, 32'h0000_00D2);
    chk_rd(csx_pkg::OffStatus, 32'h0000_00D2, "status write");
    $display("Test restore done");
  endtask

  initial begin
    rst = 1'b1;
    awValid = 1'b0;
    wValid = 1'b0;
    arValid = 1'b0;
    bReady = 1'b1;
    rReady = 1'b1;
    wStrb = 4'hF;
    awAddr = 8'h00;
    arAddr = 8'h00;
    wData = 32'h0;
    failures = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_enter();
    t_compact();
    t_exc();
    t_restore();
    final_report();
  end
endmodule

// *** design/csx_core.sv ***
// Compact/full-width state, program counter and exception link logic.
// Software drives it over AXI4-Lite; one write and one read at a time.
//
// Functional notes
// RQ1 - Compact instructions are single 16-bit words
// RQ2 - Low eight registers shared across both states
// RQ3 - Compact pc read: bit0 zero, pc above
// RQ4 - Compact pc write discards bit 0
// RQ5 - Compact pc read gives instruction address plus four
// RQ6 - State flag sits at status bit 5
// RQ7 - Flag clear: 32-bit fetch, pc plus four
// RQ8 - Flag set: 16-bit fetch, pc plus two
// RQ9 - No saved-status access from compact code
// RQ10 - Branch-exchange selects state from bit 0
// RQ11 - Link-exchange and pc loads select likewise
// RQ12 - Status restore enters compact if saved flag
// RQ13 - Software never writes state flag directly
// RQ14 - Exceptions switch to full-width state first
// RQ15 - Exception entry saves flag in saved status
// RQ16 - Undefined or software interrupt link plus two
// RQ17 - Prefetch abort link is fetch plus four
// RQ18 - Data abort link is instruction plus eight
// RQ19 - Interrupt link is next instruction plus four
// RQ20 - Skip data abort: subtract six, restore
// RQ21 - Retry undefined: subtract two, restore
// RQ22 - Handler checks saved flag before returning
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module csx_core (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      fetchAddr,
  output logic             fetchHalf,
  output logic             compactState
);

  function automatic logic [31:0] strobeMerge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  csx_pkg::csx_arch_s   arch_q;
  csx_pkg::csx_arch_s   arch_d;
  csx_pkg::csx_state_e  state_q;
  csx_pkg::csx_state_e  state_d;
  logic [31:0]          ctrl_q;
  logic [31:0]          operand_q;
  logic [31:0]          instr_q;
  logic [3:0]           cmd_q;
  logic [31:0]          lowRegs_q [csx_pkg::NumLowRegs];
  logic                 awHeld_q;
  logic [7:0]           awAddr_q;
  logic                 wHeld_q;
  logic [31:0]          wData_q;
  logic [3:0]           wStrb_q;
  logic                 bValid_q;
  logic [1:0]           bResp_q;
  logic                 rValid_q;
  logic [31:0]          rData_q;
  logic [1:0]           rResp_q;

  // Write channel capture, either order
  wire         wrFire   = awHeld_q && wHeld_q && !bValid_q;
  assign s_axi_awready  = !awHeld_q;
  assign s_axi_wready   = !wHeld_q;
  assign s_axi_bvalid   = bValid_q;
  assign s_axi_bresp    = bResp_q;
  assign s_axi_arready  = !rValid_q;
  assign s_axi_rvalid   = rValid_q;
  assign s_axi_rdata    = rData_q;
  assign s_axi_rresp    = rResp_q;

  wire         tFlag     = arch_q.status[csx_pkg::TBit];  // [RQ6]
  assign compactState    = tFlag;
  assign fetchHalf       = tFlag;  // [RQ1]
  assign fetchAddr       = arch_q.pc;

  // Pc as compact code sees it: bit 0 forced low [RQ3] [RQ5]
  wire [31:0]  pcView    = {arch_q.pc[31:1] + 31'(csx_pkg::PcReadOff >> 1), 1'b0};
  wire [31:0]  stepInc   = tFlag ? csx_pkg::IncCompact : csx_pkg::IncFull;  // [RQ7] [RQ8]
  wire [31:0]  nextPc    = arch_q.pc + stepInc;
  wire [31:0]  linkFetch = arch_q.pc + csx_pkg::LinkPabt;
  wire [31:0]  ctrlView  = {ctrl_q[31:2], (state_q == csx_pkg::ST_EXEC), tFlag};

  // Write address decode
  wire         wCtrl     = awAddr_q == csx_pkg::OffCtrl;
  wire         wStatus   = awAddr_q == csx_pkg::OffStatus;
  wire         wOperand  = awAddr_q == csx_pkg::OffOperand;
  wire         wCmd      = awAddr_q == csx_pkg::OffCmd;
  wire         wInstr    = awAddr_q == csx_pkg::OffInstr;
  wire         wSaved    = awAddr_q == csx_pkg::OffSaved;
  wire         wLow      = awAddr_q[7:5] == csx_pkg::OffReg0[7:5];
  wire         wMapped   = wCtrl || wStatus || wOperand || wCmd || wInstr || wSaved || wLow;

  // Read address decode
  logic [31:0] rdMux;
  logic        rdHit;
  always_comb begin
    rdHit = 1'b1;
    if (s_axi_araddr == csx_pkg::OffCtrl) begin
      rdMux = ctrlView;
    end else if (s_axi_araddr == csx_pkg::OffStatus) begin
      rdMux = arch_q.status;
    end else if (s_axi_araddr == csx_pkg::OffPc) begin
      rdMux = tFlag ? pcView : arch_q.pc;
    end else if (s_axi_araddr == csx_pkg::OffLink) begin
      rdMux = arch_q.link;
    end else if (s_axi_araddr == csx_pkg::OffSaved) begin
      // Hidden from compact code [RQ9]
      rdMux = tFlag ? '0 : arch_q.saved;
    end else if (s_axi_araddr == csx_pkg::OffOperand) begin
      rdMux = operand_q;
    end else if (s_axi_araddr == csx_pkg::OffInstr) begin
      rdMux = instr_q;
    end else if (s_axi_araddr[7:5] == csx_pkg::OffReg0[7:5]) begin
      rdMux = lowRegs_q[s_axi_araddr[4:2]];  // [RQ2]
    end else begin
      rdMux = '0;
      rdHit = 1'b0;
    end
  end

  // Command execution
  logic [3:0]  newMode;
  always_comb begin
    arch_d  = arch_q;
    state_d = state_q;
    newMode = 4'h0;
    case (state_q)
      csx_pkg::ST_IDLE: begin
        if (cmd_q != 4'(csx_pkg::CMD_NONE)) begin
          state_d = csx_pkg::ST_EXEC;
        end
      end
      csx_pkg::ST_EXEC: begin
        state_d = csx_pkg::ST_DONE;
        case (csx_pkg::csx_cmd_e'(cmd_q))
          csx_pkg::CMD_STEP: begin
            arch_d.pc = nextPc;
          end
          csx_pkg::CMD_BX, csx_pkg::CMD_LDPC: begin
            arch_d.pc = {operand_q[31:1], 1'b0};
            arch_d.status[csx_pkg::TBit] = operand_q[0];  // [RQ10] [RQ11]
          end
          csx_pkg::CMD_BLX: begin
            arch_d.link = tFlag ? {nextPc[31:1], 1'b1} : nextPc;
            arch_d.pc = {operand_q[31:1], 1'b0};
            arch_d.status[csx_pkg::TBit] = operand_q[0];  // [RQ11]
          end
          csx_pkg::CMD_PCWR: begin
            // Compact write drops bit 0 [RQ4]
            arch_d.pc = tFlag ? {operand_q[31:1], 1'b0} : operand_q;
          end
          csx_pkg::CMD_RESTORE: begin
            // Whole status restored, state flag included [RQ12]
            arch_d.status = arch_q.saved;
            arch_d.pc = {operand_q[31:1], 1'b0};
          end
          csx_pkg::CMD_UND, csx_pkg::CMD_SWI, csx_pkg::CMD_PABT,
          csx_pkg::CMD_DABT, csx_pkg::CMD_IRQ, csx_pkg::CMD_FIQ: begin
            arch_d.saved = arch_q.status;  // [RQ15]
            arch_d.status[csx_pkg::TBit] = 1'b0;  // [RQ14]
            newMode = cmd_q;
          end
          default: begin
          end
        endcase
        // Link values and vectors
        case (csx_pkg::csx_cmd_e'(newMode))
          csx_pkg::CMD_UND: begin
            arch_d.link = tFlag ? arch_q.pc + csx_pkg::LinkUndSwi : nextPc;  // [RQ16]
            arch_d.pc = csx_pkg::VecUnd;
          end
          csx_pkg::CMD_SWI: begin
            arch_d.link = tFlag ? arch_q.pc + csx_pkg::LinkUndSwi : nextPc;  // [RQ16]
            arch_d.pc = csx_pkg::VecSwi;
          end
          csx_pkg::CMD_PABT: begin
            arch_d.link = linkFetch;  // [RQ17]
            arch_d.pc = csx_pkg::VecPabt;
          end
          csx_pkg::CMD_DABT: begin
            arch_d.link = arch_q.pc + csx_pkg::LinkDabt;  // [RQ18]
            arch_d.pc = csx_pkg::VecDabt;
          end
          csx_pkg::CMD_IRQ: begin
            arch_d.link = arch_q.pc + csx_pkg::LinkIrq;  // [RQ19]
            arch_d.pc = csx_pkg::VecIrq;
          end
          csx_pkg::CMD_FIQ: begin
            arch_d.link = arch_q.pc + csx_pkg::LinkIrq;  // [RQ19]
            arch_d.pc = csx_pkg::VecFiq;
          end
          default: begin
          end
        endcase
      end
      csx_pkg::ST_DONE: begin
        state_d = csx_pkg::ST_IDLE;
      end
      default: begin
        state_d = csx_pkg::ST_IDLE;
      end
    endcase
    // Direct status write keeps the state flag; the live bus data may already have moved on
    if (wrFire && wStatus) begin
      arch_d.status = strobeMerge(arch_q.status, wData_q, wStrb_q) & ~(32'h1 << csx_pkg::TBit)
                      | (arch_q.status & (32'h1 << csx_pkg::TBit));
    end
    if (wrFire && wSaved && !tFlag) begin
      arch_d.saved = strobeMerge(arch_q.saved, wData_q, wStrb_q);  // [RQ9]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arch_q   <= '{pc: csx_pkg::ResetPc, status: csx_pkg::ResetStatus,
                    saved: '0, link: '0};
      state_q  <= csx_pkg::ST_IDLE;
    end else begin
      arch_q   <= arch_d;
      state_q  <= state_d;
    end
  end

  // Bus side registers
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      bValid_q  <= 1'b0;
      rValid_q  <= 1'b0;
      awAddr_q  <= '0;
      wData_q   <= '0;
      wStrb_q   <= '0;
      bResp_q   <= csx_pkg::RespOkay;
      rData_q   <= '0;
      rResp_q   <= csx_pkg::RespOkay;
    end else begin
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire) begin
        bValid_q <= 1'b1;
        bResp_q  <= wMapped ? csx_pkg::RespOkay : csx_pkg::RespSlvErr;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
      end
      if (s_axi_arvalid && !rValid_q) begin
        rValid_q <= 1'b1;
        rData_q  <= rdMux;
        rResp_q  <= rdHit ? csx_pkg::RespOkay : csx_pkg::RespSlvErr;
      end else if (rValid_q && s_axi_rready) begin
        rValid_q <= 1'b0;
      end
    end
  end

  // Software register file and command slot
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q    <= '0;
      operand_q <= '0;
      instr_q   <= '0;
      cmd_q     <= 4'(csx_pkg::CMD_NONE);
      for (int i = 0; i < csx_pkg::NumLowRegs; i++) begin
        lowRegs_q[i] <= '0;
      end
    end else begin
      if (wrFire && wCtrl) begin
        ctrl_q <= strobeMerge(ctrl_q, wData_q, wStrb_q);
      end
      if (wrFire && wOperand) begin
        operand_q <= strobeMerge(operand_q, wData_q, wStrb_q);
      end
      if (wrFire && wInstr) begin
        // Compact state keeps only the low halfword [RQ1]
        instr_q <= tFlag ? {16'h0000, wData_q[15:0]} : wData_q;
      end
      if (wrFire && wLow) begin
        // One bank for both states [RQ2]
        lowRegs_q[awAddr_q[4:2]] <= strobeMerge(lowRegs_q[awAddr_q[4:2]], wData_q, wStrb_q);
      end
      // Command accepted only while idle; finished commands clear
      if (wrFire && wCmd && state_q == csx_pkg::ST_IDLE) begin
        cmd_q <= wData_q[3:0];
      end else if (state_q == csx_pkg::ST_DONE) begin
        cmd_q <= 4'(csx_pkg::CMD_NONE);
      end
    end
  end

endmodule

// *** design/csx_pkg.sv ***
// Package for the compact-state exception link block.
// Assumes a 32-bit core with AXI4-Lite register access.
package csx_pkg;
  localparam int          DataW        = 32;
  localparam int          TBit         = 5;
  localparam logic [31:0] IncFull      = 32'h0000_0004;
  localparam logic [31:0] IncCompact   = 32'h0000_0002;
  localparam logic [31:0] PcReadOff    = 32'h0000_0004;
  localparam logic [31:0] LinkUndSwi   = 32'h0000_0002;
  localparam logic [31:0] LinkPabt     = 32'h0000_0004;
  localparam logic [31:0] LinkDabt     = 32'h0000_0008;
  localparam logic [31:0] LinkIrq      = 32'h0000_0004;
  localparam logic [31:0] ResetPc      = 32'h0000_0000;
  localparam logic [31:0] ResetStatus  = 32'h0000_00D3;
  localparam logic [31:0] VecUnd       = 32'h0000_0004;
  localparam logic [31:0] VecSwi       = 32'h0000_0008;
  localparam logic [31:0] VecPabt      = 32'h0000_000C;
  localparam logic [31:0] VecDabt      = 32'h0000_0010;
  localparam logic [31:0] VecIrq       = 32'h0000_0018;
  localparam logic [31:0] VecFiq       = 32'h0000_001C;
  localparam logic [1:0]  RespOkay     = 2'h0;
  localparam logic [1:0]  RespSlvErr   = 2'h2;
  // Register byte offsets
  localparam logic [7:0]  OffCtrl      = 8'h00;
  localparam logic [7:0]  OffStatus    = 8'h04;
  localparam logic [7:0]  OffPc        = 8'h08;
  localparam logic [7:0]  OffLink      = 8'h0C;
  localparam logic [7:0]  OffSaved     = 8'h10;
  localparam logic [7:0]  OffOperand   = 8'h14;
  localparam logic [7:0]  OffCmd       = 8'h18;
  localparam logic [7:0]  OffInstr     = 8'h1C;
  localparam logic [7:0]  OffReg0      = 8'h20;
  localparam int          NumLowRegs   = 8;

  // Commands written to OffCmd
  typedef enum logic [3:0] {
    CMD_NONE    = 4'h0,
    CMD_STEP    = 4'h1,
    CMD_BX      = 4'h2,
    CMD_BLX     = 4'h3,
    CMD_LDPC    = 4'h4,
    CMD_RESTORE = 4'h5,
    CMD_UND     = 4'h6,
    CMD_SWI     = 4'h7,
    CMD_PABT    = 4'h8,
    CMD_DABT    = 4'h9,
    CMD_IRQ     = 4'hA,
    CMD_FIQ     = 4'hB,
    CMD_PCWR    = 4'hC
  } csx_cmd_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } csx_state_e;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] status;
    logic [31:0] saved;
    logic [31:0] link;
  } csx_arch_s;
endpackage
